// ---- core/lane_packer_pkg.sv ----
// What this block does
// - Lanes carrying no converter data are powered down automatically.
// - Frames hold only sample and tail bits; control words per frame is zero.
// - Normal packing or single converter per octet, chosen by packing mode select.
// - Converters per lane 8, 4 or 2 gives 2, 4 or 8 lanes.
// - Width above resolution pads zeros below the sample LSB.
// - Normal packing cuts words into nibbles MSB first, two per octet.
// - At 8 or 4 converters per lane words pack densely across nibbles.
// - N', F and L are derived by the device from the settings.
// - At 2 converters per lane incomplete nibbles get zero tail bits.
// - Single converter per octet uses two octets per sample, N' 16.
// - Unused low bits of the second octet are zero tail bits.
// - Converters leave in ascending order, each sample MSB first.
// - Every active lane packs like lane one with its own converter group.
// - Lane i carries converters from 2*i, only on lanes the count selects.
// - One sample per converter per frame.
package lane_packer_pkg;

  localparam int NUM_CONV = 16;
  localparam int NUM_LANES = 8;
  localparam int SAMPLE_W = 16;
  localparam int OCTET_W = 8;
  localparam int FRAME_BITS = 128;
  localparam int FIFO_DEPTH = 16;
  localparam int CONVS_FIRST_LANE_STEP = 2;

  localparam logic [4:0] SLOT_SINGLE = 5'h10;
  localparam logic [4:0] SLOT_SHORT = 5'h0C;
  localparam logic [4:0] SLOT_LONG = 5'h10;
  localparam logic [4:0] CF_ZERO = 5'h00;

  // Reset configuration
  localparam logic RST_SINGLE = 1'b0;
  localparam logic [4:0] RST_WIDTH = 5'h0C;
  localparam logic [4:0] RST_RES = 5'h0C;
  localparam logic [3:0] RST_CPL = 4'h4;

  typedef struct packed {
    logic [NUM_CONV-1:0][SAMPLE_W-1:0] sample;
  } sampleFrame_t;

  typedef struct packed {
    logic [NUM_LANES-1:0][OCTET_W-1:0] octet;
  } laneOctets_t;

  typedef struct packed {
    logic single;
    logic [4:0] width;
    logic [4:0] res;
    logic [3:0] cpl;
  } packCfg_t;

endpackage

// ---- core/sample_fifo.sv ----
`timescale 1ns/1ps
module sample_fifo #(
  parameter int WIDTH = 256,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] count_q;
  logic notFull_q;
  logic notEmpty_q;
  logic push;
  logic pop;
  logic [AW:0] count_d;

  assign push = inValid && notFull_q;
  assign pop = outReady && notEmpty_q;
  assign inReady = notFull_q;
  assign outValid = notEmpty_q;
  assign outData = mem[rdPtr_q];

  always_comb begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + (AW+1)'(1);
    end else if (pop && !push) begin
      count_d = count_q - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
      notFull_q <= 1'b1;
      notEmpty_q <= 1'b0;
    end else begin
      if (push) begin
        wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + AW'(1);
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + AW'(1);
      end
      count_q <= count_d;
      notFull_q <= (count_d != (AW+1)'(DEPTH));
      notEmpty_q <= (count_d != '0);
    end
  end

endmodule

// ---- core/lane_sample_packer.sv ----
`timescale 1ns/1ps
module lane_sample_packer #(
  parameter int FIFO_DEPTH = lane_packer_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Configuration
  input wire logic packingModeSelect,
  input wire logic [4:0] serialWordWidth,
  input wire logic [4:0] sampleResolution,
  input wire logic [3:0] convertersPerLaneCount,
  input wire logic linkEnable,
  // Sample input
  input wire logic sampleValid,
  output logic sampleReady,
  input wire lane_packer_pkg::sampleFrame_t sampleFrame,
  // Lane output
  output lane_packer_pkg::laneOctets_t laneOctets,
  output logic octetValid,
  output logic frameStart,
  output logic frameEnd,
  output logic [lane_packer_pkg::NUM_LANES-1:0] lanePowerDown,
  // Derived link parameters
  output logic [4:0] nPrime,
  output logic [4:0] octetsPerFrame,
  output logic [3:0] laneCount,
  output logic [4:0] controlWordsPerFrame,
  output logic cfgRejected
);

  // ------------------------------------------------------------
  // Derivation functions
  // ------------------------------------------------------------
  function automatic logic [4:0] slotBits(input lane_packer_pkg::packCfg_t c);
    logic [4:0] s;
    s = c.width;
    if (c.single) begin
      s = lane_packer_pkg::SLOT_SINGLE;
    end else if (c.cpl == 4'h2) begin
      s = (c.width <= 5'h0C) ? lane_packer_pkg::SLOT_SHORT : lane_packer_pkg::SLOT_LONG;
    end
    return s;
  endfunction

  // Same expression covers every mode: cpl*N'/8
  function automatic logic [4:0] framesOctets(input lane_packer_pkg::packCfg_t c);
    logic [8:0] bits;
    bits = 9'(c.cpl) * 9'(slotBits(c));
    return bits[7:3];
  endfunction

  function automatic logic laneActive(input lane_packer_pkg::packCfg_t c, input int lane);
    int stride;
    stride = int'(c.cpl) / lane_packer_pkg::CONVS_FIRST_LANE_STEP;
    return (lane % stride) == 0;
  endfunction

  function automatic logic cfgLegal(input logic [4:0] w, input logic [4:0] r, input logic [3:0] n);
    logic wOk;
    logic rOk;
    logic nOk;
    wOk = (w == 5'h0A) || (w == 5'h0C) || (w == 5'h0E) || (w == 5'h10);
    rOk = (r == 5'h0A) || (r == 5'h0C) || (r == 5'h0E) || (r == 5'h10);
    nOk = (n == 4'h2) || (n == 4'h4) || (n == 4'h8);
    return wOk && rOk && nOk && (w >= r);
  endfunction

  // Each sample sits left-justified in an N'-bit slot; bits below it are zero.
  // Slots are laid back to back from the frame's MSB, so dense packing,
  // zero padding and tail bits all fall out of one placement.
  function automatic logic [lane_packer_pkg::FRAME_BITS-1:0] packLane(
    input lane_packer_pkg::sampleFrame_t s,
    input lane_packer_pkg::packCfg_t c,
    input int lane
  );
    logic [lane_packer_pkg::FRAME_BITS-1:0] v;
    logic [lane_packer_pkg::SAMPLE_W-1:0] aligned;
    logic [4:0] slot;
    int idx;
    v = '0;
    slot = slotBits(c);
    for (int k = 0; k < 8; k++) begin
      idx = lane_packer_pkg::CONVS_FIRST_LANE_STEP * lane + k;
      if (k < int'(c.cpl) && idx < lane_packer_pkg::NUM_CONV) begin
        aligned = s.sample[idx] << (lane_packer_pkg::SAMPLE_W - int'(c.res));
        v = v | ({aligned, 112'h0} >> (k * int'(slot)));
      end
    end
    return v;
  endfunction

  // ------------------------------------------------------------
  // Input buffering
  // ------------------------------------------------------------
  lane_packer_pkg::sampleFrame_t fifoData;
  logic fifoValid;
  logic fifoPop;
  logic fifoReady;

  sample_fifo #(
    .WIDTH($bits(lane_packer_pkg::sampleFrame_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .inValid(sampleValid),
    .inReady(fifoReady),
    .inData(sampleFrame),
    .outValid(fifoValid),
    .outReady(fifoPop),
    .outData(fifoData)
  );

  assign sampleReady = fifoReady;

  // ------------------------------------------------------------
  // Active configuration
  // ------------------------------------------------------------
  lane_packer_pkg::packCfg_t cfg_q;
  logic busy;
  logic cfgOpen;
  logic cfgOk;
  logic cfgRejected_q;

  // Taken only between frames, so a frame never mixes two layouts
  assign cfgOpen = !linkEnable && !busy;
  assign cfgOk = cfgLegal(serialWordWidth, sampleResolution, convertersPerLaneCount);

  // Frozen while frames flow; an illegal set is ignored, old one kept
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_q.single <= lane_packer_pkg::RST_SINGLE;
      cfg_q.width <= lane_packer_pkg::RST_WIDTH;
      cfg_q.res <= lane_packer_pkg::RST_RES;
      cfg_q.cpl <= lane_packer_pkg::RST_CPL;
    end else if (cfgOpen && cfgOk) begin
      cfg_q.single <= packingModeSelect;
      cfg_q.width <= serialWordWidth;
      cfg_q.res <= sampleResolution;
      cfg_q.cpl <= convertersPerLaneCount;
    end
  end

  // Status follows the last set presented while open
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfgRejected_q <= 1'b0;
    end else if (cfgOpen) begin
      cfgRejected_q <= !cfgOk;
    end
  end

  assign cfgRejected = cfgRejected_q;

  // ------------------------------------------------------------
  // Derived parameters and lane power
  // ------------------------------------------------------------
  logic [4:0] nPrime_q;
  logic [4:0] octets_q;
  logic [3:0] laneCount_q;
  logic [4:0] cf_q;
  logic [lane_packer_pkg::NUM_LANES-1:0] powerDown_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nPrime_q <= '0;
      octets_q <= '0;
      laneCount_q <= '0;
      cf_q <= lane_packer_pkg::CF_ZERO;
    end else begin
      nPrime_q <= slotBits(cfg_q);
      octets_q <= framesOctets(cfg_q);
      laneCount_q <= 4'(lane_packer_pkg::NUM_CONV / int'(cfg_q.cpl));
      cf_q <= lane_packer_pkg::CF_ZERO;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      powerDown_q <= '1;
    end else begin
      for (int i = 0; i < lane_packer_pkg::NUM_LANES; i++) begin
        powerDown_q[i] <= !laneActive(cfg_q, i);
      end
    end
  end

  assign nPrime = nPrime_q;
  assign octetsPerFrame = octets_q;
  assign laneCount = laneCount_q;
  assign controlWordsPerFrame = cf_q;
  assign lanePowerDown = powerDown_q;

  // ------------------------------------------------------------
  // Frame sequencing
  // ------------------------------------------------------------
  typedef enum logic {
    SeqIdle,
    SeqSend
  } seqState_t;

  seqState_t state_q;
  logic [lane_packer_pkg::FRAME_BITS-1:0] frameVec_q [lane_packer_pkg::NUM_LANES];
  logic [4:0] octetCnt_q;
  logic lastOctet;
  logic loadFrame;
  logic [4:0] curOctets;

  // Count from cfg_q directly so a frame never waits on the derived copy
  assign curOctets = framesOctets(cfg_q);
  assign busy = (state_q == SeqSend);
  assign lastOctet = busy && (octetCnt_q == curOctets - 5'h01);
  assign loadFrame = linkEnable && fifoValid && (!busy || lastOctet);
  assign fifoPop = loadFrame;

  // Reloading on the last octet keeps buffered frames back to back
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= SeqIdle;
    end else begin
      unique case (state_q)
        SeqIdle: begin
          if (loadFrame) begin
            state_q <= SeqSend;
          end
        end
        SeqSend: begin
          if (lastOctet && !loadFrame) begin
            state_q <= SeqIdle;
          end
        end
      endcase
    end
  end

  // Restarting at zero puts the first converter's MSBs in octet one
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      octetCnt_q <= '0;
    end else if (loadFrame || lastOctet) begin
      octetCnt_q <= '0;
    end else if (busy) begin
      octetCnt_q <= octetCnt_q + 5'h01;
    end
  end

  // Left shift hands up the next octet; vacated bits are zero tail
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < lane_packer_pkg::NUM_LANES; i++) begin
        frameVec_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < lane_packer_pkg::NUM_LANES; i++) begin
        if (loadFrame) begin
          frameVec_q[i] <= laneActive(cfg_q, i) ? packLane(fifoData, cfg_q, i) : '0;
        end else if (busy) begin
          frameVec_q[i] <= frameVec_q[i] << lane_packer_pkg::OCTET_W;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Output octets
  // ------------------------------------------------------------
  lane_packer_pkg::laneOctets_t octetsOut_q;
  logic octetValid_q;
  logic frameStart_q;
  logic frameEnd_q;

  // Powered-down lanes hold zero so they never toggle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      octetsOut_q <= '0;
    end else begin
      for (int i = 0; i < lane_packer_pkg::NUM_LANES; i++) begin
        octetsOut_q.octet[i] <= busy ? frameVec_q[i][lane_packer_pkg::FRAME_BITS-1 -: 8] : 8'h00;
      end
    end
  end

  // Flags share the octet's cycle so a receiver can frame on them
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      octetValid_q <= 1'b0;
      frameStart_q <= 1'b0;
      frameEnd_q <= 1'b0;
    end else begin
      octetValid_q <= busy;
      frameStart_q <= busy && (octetCnt_q == 5'h00);
      frameEnd_q <= lastOctet;
    end
  end

  assign laneOctets = octetsOut_q;
  assign octetValid = octetValid_q;
  assign frameStart = frameStart_q;
  assign frameEnd = frameEnd_q;

endmodule

// ---- verification/lane_sample_packer_assertions.sv ----
`timescale 1ns/1ps
module lane_sample_packer_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Lane output
  input wire lane_packer_pkg::laneOctets_t laneOctets,
  input wire logic octetValid,
  input wire logic frameStart,
  input wire logic frameEnd,
  input wire logic [lane_packer_pkg::NUM_LANES-1:0] lanePowerDown,
  // Derived parameters
  input wire logic [4:0] nPrime,
  input wire logic [4:0] octetsPerFrame,
  input wire logic [3:0] laneCount,
  input wire logic [4:0] controlWordsPerFrame
);
  logic [4:0] cnt_q;
  logic [4:0] cntNow;
  logic leak;
  assign cntNow = frameStart ? 5'h01 : cnt_q + 5'h01;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 5'h00;
    end else if (octetValid) begin
      cnt_q <= cntNow;
    end
  end
  always_comb begin
    leak = 1'b0;
    for (int i = 0; i < 8; i++) begin
      leak = leak | (lanePowerDown[i] & (|laneOctets.octet[i]));
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence sClose;
    octetValid && frameEnd;
  endsequence
  a_cf_zero: assert property (controlWordsPerFrame == 5'h00)
    else $error("control word count nonzero");
  a_down_quiet: assert property (!leak)
    else $error("powered-down lane carries data");
  a_lanes_on: assert property (octetValid |-> $countones(~lanePowerDown) == laneCount)
    else $error("active lanes differ from lane count");
  a_frame_len: assert property (sClose |-> cntNow == octetsPerFrame)
    else $error("frame length differs from F");
  a_next_fresh: assert property (sClose |=> !octetValid || frameStart)
    else $error("octet after frame end without frame start");
  a_frame_size: assert property (octetValid |-> 8 * octetsPerFrame == nPrime * (16 / laneCount))
    else $error("F does not match N' and lane count");
  a_np_legal: assert property (octetValid |-> nPrime inside {5'h0A, 5'h0C, 5'h0E, 5'h10})
    else $error("N' outside legal set");
  a_cfg_hold: assert property (octetValid && !frameEnd |=> $stable({nPrime, octetsPerFrame, laneCount}))
    else $error("derived values moved inside a frame");
endmodule
bind lane_sample_packer lane_sample_packer_assertions chk (.clk(clk), .rstn(rstn), .laneOctets(laneOctets),
  .octetValid(octetValid), .frameStart(frameStart), .frameEnd(frameEnd), .lanePowerDown(lanePowerDown),
  .nPrime(nPrime), .octetsPerFrame(octetsPerFrame), .laneCount(laneCount),
  .controlWordsPerFrame(controlWordsPerFrame));

// ---- verification/lane_frame_receiver.sv ----
`timescale 1ns/1ps
module lane_frame_receiver (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Lane input
  input wire lane_packer_pkg::laneOctets_t laneOctets,
  input wire logic octetValid,
  input wire logic frameStart,
  input wire logic frameEnd,
  // Collected frame
  output logic [7:0][127:0] rxFrame,
  output int rxOctets,
  output logic rxDone
);
  logic [7:0][127:0] acc = '0;
  int n = 0;
  // Octets stored left-justified, so a short frame keeps a zero tail
  always @(posedge clk) begin
    rxDone <= 1'b0;
    if (rstn && octetValid) begin
      if (frameStart) begin
        acc = '0;
        n = 0;
      end
      for (int i = 0; i < 8; i++) begin
        if (n < 16) acc[i][127-8*n -: 8] = laneOctets.octet[i];
      end
      n++;
      if (frameEnd) begin
        rxFrame <= acc;
        rxOctets <= n;
        rxDone <= 1'b1;
      end
    end
  end
endmodule

// ---- verification/lane_sample_packer_tb.sv ----
`timescale 1ns/1ps
module lane_sample_packer_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic mode = 1'b0;
  logic [4:0] width = 5'h0C;
  logic [4:0] res = 5'h0C;
  logic [3:0] cpl = 4'h4;
  logic linkEn = 1'b0;
  logic sValid = 1'b0;
  lane_packer_pkg::sampleFrame_t sFrame = '0;
  lane_packer_pkg::laneOctets_t octs;
  logic sReady, oValid, fStart, fEnd, rej, rxDone;
  logic [7:0] pDown;
  logic [4:0] np, fOct, cf;
  logic [3:0] lc;
  logic [7:0][127:0] rxFrame;
  logic [1023:0] e;
  logic [1023:0] expQ[$];
  int expF[$];
  int rxOctets, n;
  int errTotal = 0;
  int checked = 0;
  int cyc = 0;
  always #12.5 clk = ~clk;
  lane_sample_packer uut (.clk(clk), .rstn(rstn), .packingModeSelect(mode), .serialWordWidth(width),
    .sampleResolution(res), .convertersPerLaneCount(cpl), .linkEnable(linkEn), .sampleValid(sValid),
    .sampleReady(sReady), .sampleFrame(sFrame), .laneOctets(octs), .octetValid(oValid), .frameStart(fStart),
    .frameEnd(fEnd), .lanePowerDown(pDown), .nPrime(np), .octetsPerFrame(fOct), .laneCount(lc),
    .controlWordsPerFrame(cf), .cfgRejected(rej));
  lane_frame_receiver rx (.clk(clk), .rstn(rstn), .laneOctets(octs), .octetValid(oValid), .frameStart(fStart),
    .frameEnd(fEnd), .rxFrame(rxFrame), .rxOctets(rxOctets), .rxDone(rxDone));
  // ------------------------------------------------------------
  // Reference model and helpers
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [127:0] x, input logic [127:0] s);
    checked++;
    if (s !== x) begin
      errTotal++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, x, s);
    end
  endtask
  task automatic stopTest();
    $display("checks %0d mismatches %0d", checked, errTotal);
    if (errTotal == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  function automatic int npOf(logic m, int w, int c);
    if (m) return 16;
    if (c == 2) return (w <= 12) ? 12 : 16;
    return w;
  endfunction
  function automatic logic [1023:0] expFrame(lane_packer_pkg::sampleFrame_t f);
    logic [1023:0] r;
    logic [127:0] a;
    int p;
    r = '0;
    p = npOf(mode, width, cpl);
    for (int i = 0; i < 8; i++) begin
      a = '0;
      if (i % (cpl / 2) == 0) begin
        for (int k = 0; k < cpl; k++) a = (a << p) | (128'(f.sample[2*i+k]) << (p - res));
        a = a << (128 - cpl * p);
      end
      r[128*i +: 128] = a;
    end
    return r;
  endfunction
  task automatic chkCfg();
    logic [7:0] pd;
    int p;
    p = npOf(mode, width, cpl);
    for (int i = 0; i < 8; i++) pd[i] = (i % (cpl / 2)) != 0;
    chk("nPrime", p, np);
    chk("octetsPerFrame", cpl * p / 8, fOct);
    chk("laneCount", 16 / cpl, lc);
    chk("lanePowerDown", pd, pDown);
    chk("controlWordsPerFrame", 0, cf);
  endtask
  task automatic setCfg(input logic m, input int w, input int r, input int c);
    linkEn = 1'b0;
    mode = m;
    width = w[4:0];
    res = r[4:0];
    cpl = c[3:0];
    repeat (3) @(posedge clk);
    #2;
  endtask
  task automatic push();
    int k;
    for (k = 0; k < 16; k++) sFrame.sample[k] = 16'($urandom & ((32'h1 << res) - 32'h1));
    sValid = 1'b1;
    k = 0;
    while (!sReady && k < 200) begin
      @(posedge clk);
      #2;
      k++;
    end
    if (k >= 200) chk("sampleReady wait", 1, sReady);
    @(posedge clk);
    #2;
    expQ.push_back(expFrame(sFrame));
    expF.push_back(cpl * npOf(mode, width, cpl) / 8);
  endtask
  task automatic drain();
    int k;
    k = 0;
    while (expQ.size() > 0 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    #2;
    chk("frames left", 0, expQ.size());
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      errTotal++;
      stopTest();
    end else if (rxDone === 1'b1 && expQ.size() > 0) begin
      e = expQ.pop_front();
      for (int i = 0; i < 8; i++) chk("lane frame", e[128*i +: 128], rxFrame[i]);
      chk("frame octets", expF.pop_front(), rxOctets);
    end else if (rxDone === 1'b1) begin
      chk("spare frame", 0, 1);
    end
  end
  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(21121));
    repeat (16) @(posedge clk);
    #2;
    rstn = 1'b1;
    repeat (3) @(posedge clk);
    #2;
    chkCfg();
    chk("sampleReady", 1, sReady);
    $display("test reset values done");
    for (int c = 2; c <= 8; c = c * 2) begin
      for (int m = 0; m < 2; m++) begin
        for (int w = 10; w <= 16; w = w + 2) begin
          setCfg(m[0], w, 10 + 2 * ($urandom % ((w - 8) / 2)), c);
          chkCfg();
          linkEn = 1'b1;
          push();
          push();
          sValid = 1'b0;
          drain();
        end
      end
    end
    $display("test mode sweep done");
    n = npOf(mode, width, cpl);
    setCfg(1'b0, 10, 12, 4);
    chk("cfgRejected", 1, rej);
    chk("nPrime kept", n, np);
    setCfg(1'b0, 12, 12, 4);
    chk("cfgRejected", 0, rej);
    $display("test illegal config done");
    n = 0;
    while (sReady && n < 20) begin
      push();
      n++;
    end
    sValid = 1'b0;
    chk("fifo depth", 16, n);
    linkEn = 1'b1;
    width = 5'h10;
    drain();
    chk("nPrime while linked", 12, np);
    linkEn = 1'b0;
    repeat (3) @(posedge clk);
    #2;
    chk("nPrime after idle", 16, np);
    $display("test fifo and config hold done");
    stopTest();
  end
endmodule
